/* verilog/sar_adc_sequencer.sv */
// Purpose: Sequencer for a 10-bit successive-approximation converter
// Assumes: Analog front end outside; inputs synchronous to sys_clk_in
// Notes: Result pair keeps its contents through reset
module sar_adc_sequencer
   import sar_adc_pkg::*;
#(
   parameter int RESULT_WIDTH = BITS
)
(
   // Clock, enable, reset
   input wire logic sys_clk_in,
   input wire logic ce_in,
   input wire logic rstn_in,
   // Power-on reset indicator, high during the power-on reset only
   input wire logic por_in,
   // Register port
   input wire logic [2:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // Analog front end
   input wire logic rc_tick_in,
   input wire logic cmp_hi_in,
   output logic [9:0] dac_code_out,
   output logic sample_out,
   output logic [3:0] channel_out,
   output logic ref_pos_pin_out,
   output logic ref_neg_pin_out,
   // Completion flag towards the interrupt controller
   output logic complete_flag_out,
   output logic complete_irq_out
);
   // Elaboration check: the packing below serves ten bits only
   if (RESULT_WIDTH != BITS) begin : g_width_check
      $error("RESULT_WIDTH must equal BITS");
   end

   typedef enum {
      ST_IDLE,
      ST_ACQ,
      ST_CONV,
      ST_WAIT
   } seq_e;

   typedef struct packed {
      seq_e state;
      logic [7:0] ctrl_zero;
      logic [7:0] ctrl_one;
      logic [7:0] ctrl_two;
      logic flag;
      logic irq_en;
      logic [9:0] result;
      logic [4:0] periods;
      logic clr_sar;
      logic [7:0] rdata;
      logic [9:0] dac;
      logic sample;
      logic irq;
   } seq_s;

   seq_s st_ff;
   seq_s nxt_st;
   logic tick;
   logic run;
   logic [9:0] trial;
   logic [9:0] code;

   // Acquisition periods for each field code
   function automatic logic [4:0] acq_periods(input logic [2:0] f);
      case (f)
         3'h1: acq_periods = 5'd2;
         3'h2: acq_periods = 5'd4;
         3'h3: acq_periods = 5'd6;
         3'h4: acq_periods = 5'd8;
         3'h5: acq_periods = 5'd12;
         3'h6: acq_periods = 5'd16;
         3'h7: acq_periods = 5'd20;
         default: acq_periods = 5'd0;
      endcase
   endfunction

   // Result byte in either justification
   function automatic logic [7:0] result_byte(input logic [9:0] r,
      input logic right, input logic high);
      logic [15:0] w;
      w = right ? {6'h00, r} : {r, 6'h00};
      result_byte = high ? w[15:8] : w[7:0];
   endfunction

   // Period ticker runs whenever a timed phase is active
   assign run = (st_ff.state != ST_IDLE);

   conv_tick_gen u_tick (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .run_in(run),
      .sel_in(st_ff.ctrl_two[CLK_LSB +: 3]),
      .rc_tick_in(rc_tick_in),
      .tick_out(tick)
   );

   sar_core #(
      .WIDTH(BITS)
   ) u_sar (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .clear_in(st_ff.clr_sar),
      .tick_in(tick && st_ff.state == ST_CONV),
      .cmp_hi_in(cmp_hi_in),
      .trial_out(trial),
      .code_out(code)
   );

   // Register access, sequencing and output staging
   always_comb begin
      logic go_wr;
      logic go_clr;
      go_wr = 1'b0;
      go_clr = 1'b0;
      nxt_st = st_ff;
      nxt_st.clr_sar = 1'b0;
      nxt_st.rdata = 8'h00;
      // Writes; the start bit is handled by the sequencer below
      if (wr_in) begin
         case (addr_in)
            OFF_RESULT_HIGH: begin
               if (st_ff.ctrl_two[FMT_BIT])
                  nxt_st.result[9:8] = wdata_in[1:0];
               else
                  nxt_st.result[9:2] = wdata_in;
            end
            OFF_RESULT_LOW: begin
               if (st_ff.ctrl_two[FMT_BIT])
                  nxt_st.result[7:0] = wdata_in;
               else
                  nxt_st.result[1:0] = wdata_in[7:6];
            end
            OFF_CTRL_ZERO: begin
               nxt_st.ctrl_zero = (wdata_in & CTRL_ZERO_MASK)
                  & ~(8'h01 << GO_BIT);
               nxt_st.ctrl_zero[GO_BIT] = st_ff.ctrl_zero[GO_BIT];
               go_wr = wdata_in[GO_BIT] & wdata_in[EN_BIT];
               go_clr = ~wdata_in[GO_BIT] | ~wdata_in[EN_BIT];
            end
            OFF_CTRL_ONE: nxt_st.ctrl_one = wdata_in & CTRL_ONE_MASK;
            OFF_CTRL_TWO: nxt_st.ctrl_two = wdata_in & CTRL_TWO_MASK;
            OFF_FLAGS: begin
               nxt_st.flag = wdata_in[FLAG_BIT];
               nxt_st.irq_en = wdata_in[IRQ_EN_BIT];
            end
            default: ;
         endcase
      end
      // Reads answer in the next cycle; unmapped reads give zero
      if (rd_in) begin
         case (addr_in)
            OFF_RESULT_HIGH: nxt_st.rdata =
               result_byte(st_ff.result, st_ff.ctrl_two[FMT_BIT], 1'b1);
            OFF_RESULT_LOW: nxt_st.rdata =
               result_byte(st_ff.result, st_ff.ctrl_two[FMT_BIT], 1'b0);
            OFF_CTRL_ZERO: nxt_st.rdata = st_ff.ctrl_zero;
            OFF_CTRL_ONE: nxt_st.rdata = st_ff.ctrl_one;
            OFF_CTRL_TWO: nxt_st.rdata = st_ff.ctrl_two;
            OFF_FLAGS: nxt_st.rdata = {6'h00, st_ff.irq_en, st_ff.flag};
            default: nxt_st.rdata = 8'h00;
         endcase
      end
      // Sequencer
      case (st_ff.state)
         ST_IDLE: begin
            if (go_wr) begin
               nxt_st.ctrl_zero[GO_BIT] = 1'b1;
               nxt_st.periods =
                  acq_periods(st_ff.ctrl_two[ACQ_LSB +: 3]);
               nxt_st.clr_sar = 1'b1;
               if (acq_periods(st_ff.ctrl_two[ACQ_LSB +: 3]) == 5'd0)
                  nxt_st.state = ST_CONV;
               else
                  nxt_st.state = ST_ACQ;
               if (nxt_st.state == ST_CONV)
                  nxt_st.periods = 5'(CONV_PERIODS);
            end
         end
         ST_ACQ: begin
            if (go_clr) begin
               nxt_st.ctrl_zero[GO_BIT] = 1'b0;
               nxt_st.state = ST_IDLE;
            end else if (tick) begin
               if (st_ff.periods == 5'd1) begin
                  nxt_st.state = ST_CONV;
                  nxt_st.periods = 5'(CONV_PERIODS);
               end else
                  nxt_st.periods = st_ff.periods - 5'd1;
            end
         end
         ST_CONV: begin
            if (go_clr) begin
               nxt_st.ctrl_zero[GO_BIT] = 1'b0;
               nxt_st.state = ST_WAIT;
               nxt_st.periods = 5'(WAIT_PERIODS);
            end else if (tick) begin
               if (st_ff.periods == 5'd1) begin
                  nxt_st.result = code;
                  nxt_st.ctrl_zero[GO_BIT] = 1'b0;
                  nxt_st.flag = 1'b1;
                  nxt_st.state = ST_WAIT;
                  nxt_st.periods = 5'(WAIT_PERIODS);
               end else
                  nxt_st.periods = st_ff.periods - 5'd1;
            end
         end
         ST_WAIT: begin
            // New starts are held off until the wait is over
            if (tick) begin
               if (st_ff.periods == 5'd1)
                  nxt_st.state = ST_IDLE;
               else
                  nxt_st.periods = st_ff.periods - 5'd1;
            end
         end
         default: nxt_st.state = ST_IDLE;
      endcase
      // Disabling the module abandons any activity
      if (!nxt_st.ctrl_zero[EN_BIT]) begin
         nxt_st.ctrl_zero[GO_BIT] = 1'b0;
         nxt_st.state = ST_IDLE;
      end
      // Staged outputs; sampling resumes outside conversion
      nxt_st.dac = trial;
      nxt_st.sample = nxt_st.ctrl_zero[EN_BIT]
         && nxt_st.state != ST_CONV;
      nxt_st.irq = nxt_st.flag & nxt_st.irq_en;
   end

   // State register; result pair survives every reset
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         st_ff.state <= ST_IDLE;
         st_ff.ctrl_zero <= CTRL_RESET;
         st_ff.ctrl_one <= CTRL_RESET;
         st_ff.ctrl_two <= CTRL_RESET;
         st_ff.flag <= 1'b0;
         st_ff.irq_en <= 1'b0;
         st_ff.periods <= 5'd0;
         st_ff.clr_sar <= 1'b0;
         st_ff.rdata <= 8'h00;
         st_ff.dac <= 10'h000;
         st_ff.sample <= 1'b0;
         st_ff.irq <= 1'b0;
         if (por_in)
            st_ff.result <= st_ff.result;
      end else if (ce_in) begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flip-flops
   assign rdata_out = st_ff.rdata;
   assign dac_code_out = st_ff.dac;
   assign sample_out = st_ff.sample;
   assign channel_out = st_ff.ctrl_zero[CHAN_LSB +: 4];
   assign ref_pos_pin_out = st_ff.ctrl_one[REF_POS_BIT];
   assign ref_neg_pin_out = st_ff.ctrl_one[REF_NEG_BIT];
   assign complete_flag_out = st_ff.flag;
   assign complete_irq_out = st_ff.irq;
endmodule

/* verilog/sar_adc_pkg.sv */
// Purpose: Shared constants for the successive-approximation sequencer
// Assumes: Byte-wide registers on a plain strobe port
// Notes: Offsets are register indices on the byte port
package sar_adc_pkg;
   // Register offsets
   localparam logic [2:0] OFF_RESULT_HIGH = 3'h0;
   localparam logic [2:0] OFF_RESULT_LOW = 3'h1;
   localparam logic [2:0] OFF_CTRL_ZERO = 3'h2;
   localparam logic [2:0] OFF_CTRL_ONE = 3'h3;
   localparam logic [2:0] OFF_CTRL_TWO = 3'h4;
   localparam logic [2:0] OFF_FLAGS = 3'h5;
   // Control zero fields
   localparam int EN_BIT = 0;
   localparam int GO_BIT = 1;
   localparam int CHAN_LSB = 2;
   // Control one fields
   localparam int REF_NEG_BIT = 5;
   localparam int REF_POS_BIT = 4;
   // Control two fields
   localparam int FMT_BIT = 7;
   localparam int ACQ_LSB = 3;
   localparam int CLK_LSB = 0;
   // Flag register fields
   localparam int FLAG_BIT = 0;
   localparam int IRQ_EN_BIT = 1;
   // Write masks of implemented bits
   localparam logic [7:0] CTRL_ZERO_MASK = 8'h3f;
   localparam logic [7:0] CTRL_ONE_MASK = 8'h3f;
   localparam logic [7:0] CTRL_TWO_MASK = 8'hbf;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   // Bit count and timing counts; RC_DELAY_CYCLES in system clocks, the rest in conversion clock periods
   localparam int BITS = 10;
   localparam int CONV_PERIODS = 11;
   localparam int WAIT_PERIODS = 2;
   localparam int RC_DELAY_CYCLES = 4;
   // Clock select code for the internal oscillator (x11)
   localparam logic [1:0] CLK_RC_LOW = 2'h3;
endpackage

/* verilog/conv_tick_gen.sv */
// Purpose: Conversion clock period tick generator
// Assumes: RC oscillator ticks arrive synchronous to sys_clk_in
// Notes: Divider restarts on each run so the first period is whole
module conv_tick_gen
   import sar_adc_pkg::*;
(
   // Clock and control
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic run_in,
   input wire logic [2:0] sel_in,
   input wire logic rc_tick_in,
   // Tick out
   output logic tick_out
);
   typedef struct packed {
      logic [5:0] cnt;
      logic [2:0] rc_wait;
      logic tick;
   } tick_s;
   tick_s st_ff, nxt_st;

   // Division ratio minus one from the select code
   function automatic logic [5:0] div_last(input logic [2:0] sel);
      case (sel)
         3'h0: div_last = 6'h01;
         3'h4: div_last = 6'h03;
         3'h1: div_last = 6'h07;
         3'h5: div_last = 6'h0f;
         3'h2: div_last = 6'h1f;
         default: div_last = 6'h3f;
      endcase
   endfunction

   // Count system clocks, or pass RC ticks after four cycles of delay
   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (!run_in) begin
         nxt_st.cnt = 6'h00;
         nxt_st.rc_wait = 3'(RC_DELAY_CYCLES);
      end else if (sel_in[1:0] == CLK_RC_LOW) begin
         if (st_ff.rc_wait != 3'h0)
            nxt_st.rc_wait = st_ff.rc_wait - 3'h1;
         else
            nxt_st.tick = rc_tick_in;
      end else if (st_ff.cnt >= div_last(sel_in)) begin
         nxt_st.cnt = 6'h00;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + 6'h01;
      end
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in)
         st_ff <= '0;
      else if (ce_in)
         st_ff <= nxt_st;
   end

   assign tick_out = st_ff.tick;
endmodule

/* verilog/sar_core.sv */
// Purpose: Successive-approximation register, one bit per period
// Assumes: Comparator output valid when a tick arrives
// Notes: Tests the MSB first; result valid after BITS ticks
module sar_core
   import sar_adc_pkg::*;
#(
   parameter int WIDTH = BITS
)
(
   // Clock and control
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic clear_in,
   input wire logic tick_in,
   input wire logic cmp_hi_in,
   // Trial code and result
   output logic [WIDTH-1:0] trial_out,
   output logic [WIDTH-1:0] code_out
);
   typedef struct packed {
      logic [WIDTH-1:0] code;
      logic [WIDTH-1:0] mask;
   } sar_s;
   sar_s st_ff, nxt_st;

   // Elaboration check: the mask needs at least two bits
   if (WIDTH < 2) begin : g_width_check
      $error("WIDTH must be at least 2");
   end

   // Keep or drop the bit under test, then try the next one
   always_comb begin
      nxt_st = st_ff;
      if (clear_in) begin
         nxt_st.code = '0;
         nxt_st.mask = {1'b1, {(WIDTH-1){1'b0}}};
      end else if (tick_in && st_ff.mask != '0) begin
         if (cmp_hi_in)
            nxt_st.code = st_ff.code | st_ff.mask;
         nxt_st.mask = st_ff.mask >> 1;
      end
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in)
         st_ff <= '0;
      else if (ce_in)
         st_ff <= nxt_st;
   end

   assign trial_out = st_ff.code | st_ff.mask;
   assign code_out = st_ff.code;
endmodule

/* dv/sar_adc_checker.sv */
// Purpose: Port-level checks of the converter sequencer
// Assumes: ce_in high around starts; code 000 gives two clocks a period
// Notes: Shadows follow control writes seen on the port
module sar_adc_checker
   import sar_adc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic ce_in,
   input wire logic rstn_in,
   // Register port
   input wire logic [2:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   // Converter side
   input wire logic [9:0] dac_code_out,
   input wire logic sample_out,
   input wire logic [3:0] channel_out,
   input wire logic ref_pos_pin_out,
   input wire logic complete_flag_out,
   input wire logic complete_irq_out
);
   logic [7:0] c0_ff, c1_ff, c2_ff, fl_ff;
   logic start_w, fast;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   // Shadow control writes; no completion side effects modelled
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         {c0_ff, c1_ff, c2_ff, fl_ff} <= 32'h0000_0000;
      end else if (wr_in && ce_in) begin
         case (addr_in)
            OFF_CTRL_ZERO: c0_ff <= wdata_in;
            OFF_CTRL_ONE: c1_ff <= wdata_in;
            OFF_CTRL_TWO: c2_ff <= wdata_in;
            OFF_FLAGS: fl_ff <= wdata_in;
            default: ;
         endcase
      end
   end
   assign start_w = wr_in && addr_in == OFF_CTRL_ZERO && wdata_in[GO_BIT]
      && wdata_in[EN_BIT] && ce_in;
   // Manual acquisition on the fastest divider only
   assign fast = c2_ff[5:0] == 6'h00;
   reset_clears_a: assert property (disable iff (1'b0)
      (!rstn_in && ce_in) |=> !complete_flag_out && !sample_out
      && channel_out == 4'h0 && !ref_pos_pin_out)
      else $error("outputs not cleared by reset");
   rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside read answer");
   go_reads_a: assert property (rd_in && addr_in == OFF_CTRL_ZERO
      && c0_ff[EN_BIT] && !sample_out |=> rdata_out[GO_BIT])
      else $error("start bit clear while converting");
   ref_pin_a: assert property (wr_in && ce_in && addr_in == OFF_CTRL_ONE
      |=> ##1 ref_pos_pin_out == c1_ff[REF_POS_BIT])
      else $error("reference select not applied");
   chan_follow_a: assert property (wr_in && ce_in && addr_in == OFF_CTRL_ZERO
      |=> ##1 channel_out == c0_ff[5:2])
      else $error("channel field not applied");
   conv_len_a: assert property (start_w && fast && !complete_flag_out
      |-> ##1 !complete_flag_out [*8] ##1 !complete_flag_out [*8]
      ##[3:10] complete_flag_out)
      else $error("conversion length wrong");
   first_trial_a: assert property (start_w && fast
      |-> ##[1:4] dac_code_out == 10'h200)
      else $error("first trial code not MSB");
   hold_off_a: assert property (start_w && fast |-> ##2 !sample_out [*8])
      else $error("sampling during conversion");
   irq_follow_a: assert property ($rose(complete_flag_out)
      && fl_ff[IRQ_EN_BIT] |-> ##[0:1] complete_irq_out)
      else $error("interrupt line not raised");
   post_wait_a: assert property ($rose(complete_flag_out)
      && c2_ff[2:0] == 3'b110 ##[1:40] start_w |=> sample_out [*8])
      else $error("start accepted in post wait");
   cover property (start_w && fast);
   cover property ($rose(complete_flag_out));
   cover property (rd_in && addr_in == OFF_CTRL_ZERO);
endmodule

bind sar_adc_sequencer sar_adc_checker chk (
   .sys_clk_in(sys_clk_in), .ce_in(ce_in), .rstn_in(rstn_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .dac_code_out(dac_code_out),
   .sample_out(sample_out), .channel_out(channel_out),
   .ref_pos_pin_out(ref_pos_pin_out),
   .complete_flag_out(complete_flag_out),
   .complete_irq_out(complete_irq_out)
);

/* dv/adc_front_model.sv */
// Purpose: Analog front end: comparator and free RC oscillator
// Assumes: Level is steady while a conversion runs
// Notes: RC oscillator runs free, also in sleep
module adc_front_model
#(
   parameter int RC_DIV = 5
)
(
   // Clock and analog level
   input wire logic sys_clk_in,
   input wire logic [9:0] level_in,
   input wire logic [9:0] dac_code_in,
   // Comparator and RC tick
   output logic cmp_hi_out,
   output logic rc_tick_out = 1'b0
);
   int cnt = 0;
   // Ideal comparator against the trial code
   assign cmp_hi_out = level_in >= dac_code_in;
   // One tick per RC period, synchronous to the system clock
   always @(posedge sys_clk_in) begin
      cnt <= (cnt == RC_DIV - 1) ? 0 : cnt + 1;
      rc_tick_out <= cnt == 0;
   end
endmodule

/* dv/tb.sv */
// Purpose: Self-checking bench for the converter sequencer
// Assumes: ce_in high except for one frozen write
// Notes: Timings compared against a manual-acquisition baseline
module tb
   import sar_adc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in = 1'b0, rstn_in = 1'b0, por_in = 1'b1;
   logic wr_in = 1'b0, rd_in = 1'b0, rd_d = 1'b0, ce = 1'b1;
   logic [2:0] addr_in = 3'h0;
   logic [7:0] wdata_in = 8'h00, rdata_out;
   logic [9:0] level = 10'h000, last, dac_code_out;
   logic [15:0] rnd = 16'h025f;
   logic [3:0] channel_out;
   logic cmp_hi_in, rc_tick_in, sample_out, rp, rn, flag, irq;
   logic [7:0] exp_q[$], msk_q[$];
   int miscompares = 0, tests_run = 0;
   int acq_t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   int div_t[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
   sar_adc_sequencer dut (.sys_clk_in(sys_clk_in), .ce_in(ce),
      .rstn_in(rstn_in), .por_in(por_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .rc_tick_in(rc_tick_in),
      .cmp_hi_in(cmp_hi_in), .dac_code_out(dac_code_out),
      .sample_out(sample_out), .channel_out(channel_out),
      .ref_pos_pin_out(rp), .ref_neg_pin_out(rn),
      .complete_flag_out(flag), .complete_irq_out(irq));
   adc_front_model afe (.sys_clk_in(sys_clk_in), .level_in(level),
      .dac_code_in(dac_code_out), .cmp_hi_out(cmp_hi_in),
      .rc_tick_out(rc_tick_in));
   always #2 sys_clk_in = ~sys_clk_in;
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic check(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic report_and_stop();
      if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Read answers are compared in the cycle after the strobe
   always @(posedge sys_clk_in) begin
      if (rd_d) begin
         check((rdata_out & msk_q[0]) === (exp_q[0] & msk_q[0]), "read");
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      rd_d <= rd_in;
   end
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      msk_q.push_back(8'hff);
      @(posedge sys_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_in <= 1'b0;
   endtask
   // Result pair in either justification
   task automatic rd_res(input logic rj);
      rd(OFF_RESULT_HIGH, rj ? {6'h00, last[9:8]} : last[9:2]);
      rd(OFF_RESULT_LOW, rj ? last[7:0] : {last[1:0], 6'h00});
   endtask
   // One conversion on a random level and channel; n is its length
   task automatic conv(input logic [7:0] c2, input int wt, output int n);
      logic [9:0] v;
      rnd = lfsr(rnd);
      v = rnd[9:0];
      level <= v;
      wr(OFF_CTRL_TWO, c2);
      wr(OFF_FLAGS, 8'h02);
      wr(OFF_CTRL_ZERO, {2'b00, rnd[13:10], 2'b11});
      n = 0;
      while (flag !== 1'b1 && n < 6000) begin
         @(posedge sys_clk_in);
         #1 n++;
      end
      check(n < 6000, "no completion");
      last = v;
      rd(OFF_CTRL_ZERO, {2'b00, rnd[13:10], 2'b01});
      rd(OFF_FLAGS, 8'h03);
      rd_res(c2[FMT_BIT]);
      repeat (wt) @(posedge sys_clk_in);
      check(sample_out === 1'b1, "not sampling");
   endtask
   initial begin
      int n0, n;
      repeat (6) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      por_in <= 1'b0;
      for (int a = 2; a < 8; a++) rd(a[2:0], 8'h00);
      wr(OFF_CTRL_TWO, 8'hff);
      rd(OFF_CTRL_TWO, 8'hbf);
      wr(OFF_CTRL_ONE, 8'hff);
      rd(OFF_CTRL_ONE, 8'h3f);
      wr(OFF_CTRL_ONE, 8'h10);
      // A write while the clock enable is low must be dropped
      @(posedge sys_clk_in);
      ce <= 1'b0;
      wr(OFF_CTRL_ONE, 8'h20);
      @(posedge sys_clk_in);
      ce <= 1'b1;
      rd(OFF_CTRL_ONE, 8'h10);
      conv(8'h80, 8, n0);
      for (int k = 1; k < 8; k++) begin
         conv({2'b10, k[2:0], 3'b000}, 8, n);
         check(n - n0 == acq_t[k] * 2, "acquisition");
      end
      // Every clock code; RC start has its extra delay
      for (int c = 0; c < 8; c++) begin
         conv({5'h00, c[2:0]}, div_t[c] * 2 + 14, n);
         if (div_t[c] != 0) check(n - n0 == (div_t[c] - 2) * 11, "div");
         else check(n >= n0 + 30 && n <= n0 + 50, "rc clock");
      end
      // Start inside the post-conversion wait is ignored
      conv(8'h06, 0, n);
      wr(OFF_CTRL_ZERO, 8'h03);
      rd(OFF_CTRL_ZERO, 8'h01);
      repeat (140) @(posedge sys_clk_in);
      // Abort mid-conversion keeps the old result
      wr(OFF_CTRL_TWO, 8'h81);
      wr(OFF_FLAGS, 8'h02);
      level <= ~last;
      wr(OFF_CTRL_ZERO, 8'h03);
      repeat (30) @(posedge sys_clk_in);
      wr(OFF_CTRL_ZERO, 8'h01);
      repeat (40) @(posedge sys_clk_in);
      rd(OFF_FLAGS, 8'h02);
      rd(OFF_CTRL_ZERO, 8'h01);
      rd_res(1'b1);
      // Reset mid-conversion clears control but keeps the result
      wr(OFF_CTRL_ZERO, 8'h03);
      repeat (20) @(posedge sys_clk_in);
      rstn_in <= 1'b0;
      @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      for (int a = 2; a < 6; a++) rd(a[2:0], 8'h00);
      rd_res(1'b0);
      repeat (4) @(posedge sys_clk_in);
      report_and_stop();
   end
   // Hang guard well beyond the expected run length
   initial begin
      #100000;
      miscompares++;
      report_and_stop();
   end
endmodule
